// file: design/nvm_cfg.svh
`ifndef NVM_CFG_SVH
`define NVM_CFG_SVH
// array shape
`define NVM_DEPTH 256
`define NVM_DW 8
`define NVM_AW 8
// register port map
`define REG_AW 3
`define OFS_DATA 3'h0
`define OFS_ADDR 3'h1
`define OFS_CTRL 3'h2
`define OFS_UNLOCK 3'h3
`define OFS_FLAG 3'h4
// control register bits
`define CTRL_FETCH 0
`define CTRL_STORE 1
`define CTRL_PERMIT 2
`define CTRL_ABORT 3
`define CTRL_HI_ZERO 4'h0
// peripheral flag register bit
`define FLAG_DONE 7
// unlock keys and spacing in clocks
`define UNLOCK_KEY1 8'h55
`define UNLOCK_KEY2 8'haa
`define UNLOCK_GAP 8'h02
// values
`define ERASED_BYTE 8'hff
`define ZERO_BYTE 8'h00
// power-up timer and store phase length
`define PWRT_MS 64
`define CLK_KHZ 40000
`define STORE_PHASE_CYCLES 40000
`endif

// file: design/nvm_pkg.sv
`default_nettype none
package nvm_pkg;
  typedef enum {ST_IDLE, ST_ERASE, ST_PROG} store_st_t;
  typedef enum {UN_IDLE, UN_KEY1, UN_KEY2} unlock_st_t;
endpackage
`default_nettype wire

// file: design/data_eeprom_access.sv
`include "nvm_cfg.svh"
`default_nettype none
module data_eeprom_access #(
  parameter int unsigned ERASE_CYCLES = `STORE_PHASE_CYCLES,
  parameter int unsigned PROG_CYCLES = `STORE_PHASE_CYCLES,
  parameter int unsigned PWRT_CYCLES = `PWRT_MS * `CLK_KHZ
) (
  // clock and power-on reset
  input wire logic mclk_i,
  input wire logic rst_n_i,
  // other system resets, one-cycle pulses
  input wire logic ext_rst_i,
  input wire logic wdt_rst_i,
  input wire logic bor_rst_i,
  // register port
  input wire logic [`REG_AW-1:0] reg_addr_i,
  input wire logic [`NVM_DW-1:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  output logic [`NVM_DW-1:0] reg_rdata_o,
  // external programmer access
  input wire logic prot_i,
  input wire logic [`NVM_AW-1:0] prog_addr_i,
  input wire logic prog_rd_i,
  output logic [`NVM_DW-1:0] prog_rdata_o,
  // status
  output logic store_done_o,
  output logic store_busy_o
);

  typedef struct packed {
    logic [`NVM_DEPTH-1:0][`NVM_DW-1:0] mem;
    logic [`NVM_DW-1:0] data;
    logic [`NVM_AW-1:0] addr;
    logic [`NVM_DW-1:0] sdata;
    logic [`NVM_AW-1:0] saddr;
    logic [`NVM_DW-1:0] rdata;
    logic [`NVM_DW-1:0] prd;
    logic fetch;
    logic store;
    logic permit;
    logic abort;
    logic done;
    nvm_pkg::store_st_t sst;
    nvm_pkg::unlock_st_t ust;
    logic [7:0] ucnt;
    logic [31:0] tcnt;
    logic [31:0] pwrt;
  } state_t;

  state_t s_r;
  state_t s_nxt;

  logic wr_data;
  logic wr_addr;
  logic wr_ctrl;
  logic wr_unlock;
  logic wr_flag;
  logic armed;
  logic soft_rst;

  assign wr_data = reg_wr_i && (reg_addr_i == `OFS_DATA);
  assign wr_addr = reg_wr_i && (reg_addr_i == `OFS_ADDR);
  assign wr_ctrl = reg_wr_i && (reg_addr_i == `OFS_CTRL);
  assign wr_unlock = reg_wr_i && (reg_addr_i == `OFS_UNLOCK);
  assign wr_flag = reg_wr_i && (reg_addr_i == `OFS_FLAG);
  assign soft_rst = ext_rst_i || wdt_rst_i || bor_rst_i;
  assign armed = (s_r.ust == nvm_pkg::UN_KEY2) && (s_r.ucnt == `UNLOCK_GAP);

  always_comb begin
    s_nxt = s_r;
    s_nxt.rdata = `ZERO_BYTE;
    s_nxt.ucnt = s_r.ucnt + 8'h01;

    // register reads, answer in next cycle only
    if (reg_rd_i) begin
      unique case (reg_addr_i)
        `OFS_DATA: s_nxt.rdata = s_r.data;
        `OFS_ADDR: s_nxt.rdata = s_r.addr;
        `OFS_CTRL: s_nxt.rdata = {`CTRL_HI_ZERO, s_r.abort, s_r.permit, s_r.store, s_r.fetch};
        `OFS_FLAG: s_nxt.rdata = {s_r.done, 7'h00};
        default: s_nxt.rdata = `ZERO_BYTE;
      endcase
    end

    if (prog_rd_i) begin
      s_nxt.prd = prot_i ? `ZERO_BYTE : s_r.mem[prog_addr_i];
    end

    if (wr_data) begin
      s_nxt.data = reg_wdata_i;
    end
    if (wr_addr) begin
      s_nxt.addr = reg_wdata_i;
    end
    if (wr_flag) begin
      s_nxt.done = reg_wdata_i[`FLAG_DONE];
    end

    unique case (s_r.ust)
      nvm_pkg::UN_IDLE: begin
        if (wr_unlock && reg_wdata_i == `UNLOCK_KEY1) begin
          s_nxt.ust = nvm_pkg::UN_KEY1;
          s_nxt.ucnt = 8'h01;
        end
      end
      nvm_pkg::UN_KEY1: begin
        if (wr_unlock && reg_wdata_i == `UNLOCK_KEY2 && s_r.ucnt == `UNLOCK_GAP) begin
          s_nxt.ust = nvm_pkg::UN_KEY2;
          s_nxt.ucnt = 8'h01;
        end else if (wr_unlock && reg_wdata_i == `UNLOCK_KEY1) begin
          s_nxt.ucnt = 8'h01;
        end else if (wr_unlock || s_r.ucnt >= `UNLOCK_GAP) begin
          s_nxt.ust = nvm_pkg::UN_IDLE;
        end
      end
      nvm_pkg::UN_KEY2: begin
        if (wr_unlock && reg_wdata_i == `UNLOCK_KEY1) begin
          s_nxt.ust = nvm_pkg::UN_KEY1;
          s_nxt.ucnt = 8'h01;
        end else if (wr_unlock || wr_ctrl || s_r.ucnt >= `UNLOCK_GAP) begin
          s_nxt.ust = nvm_pkg::UN_IDLE;
        end
      end
    endcase

    if (wr_ctrl) begin
      s_nxt.permit = reg_wdata_i[`CTRL_PERMIT];
      s_nxt.abort = reg_wdata_i[`CTRL_ABORT];
      s_nxt.fetch = s_r.fetch || reg_wdata_i[`CTRL_FETCH];
      if (reg_wdata_i[`CTRL_STORE] && s_r.permit && armed && s_r.pwrt == 32'h0 && !s_r.store) begin
        s_nxt.store = 1'b1;
        s_nxt.sst = nvm_pkg::ST_ERASE;
        s_nxt.tcnt = 32'h0;
        s_nxt.saddr = s_r.addr;
        s_nxt.sdata = s_r.data;
      end
    end

    if (s_r.fetch && s_r.sst == nvm_pkg::ST_IDLE) begin
      s_nxt.data = s_r.mem[s_r.addr];
      s_nxt.fetch = 1'b0;
    end

    unique case (s_r.sst)
      nvm_pkg::ST_IDLE: begin
      end
      nvm_pkg::ST_ERASE: begin
        s_nxt.tcnt = s_r.tcnt + 32'h1;
        if (s_r.tcnt >= 32'(ERASE_CYCLES - 1)) begin
          s_nxt.mem[s_r.saddr] = `ERASED_BYTE;
          s_nxt.sst = nvm_pkg::ST_PROG;
          s_nxt.tcnt = 32'h0;
        end
      end
      nvm_pkg::ST_PROG: begin
        s_nxt.tcnt = s_r.tcnt + 32'h1;
        if (s_r.tcnt >= 32'(PROG_CYCLES - 1)) begin
          s_nxt.mem[s_r.saddr] = s_r.sdata;
          s_nxt.sst = nvm_pkg::ST_IDLE;
          s_nxt.store = 1'b0;
          // done flag set wins over a flag-register write clear
          s_nxt.done = 1'b1;
        end
      end
    endcase

    if (s_r.pwrt != 32'h0) begin
      s_nxt.pwrt = s_r.pwrt - 32'h1;
    end

    if (soft_rst) begin
      s_nxt.abort = s_r.abort || s_r.store;
      s_nxt.data = `ZERO_BYTE;
      s_nxt.addr = `ZERO_BYTE;
      s_nxt.fetch = 1'b0;
      s_nxt.store = 1'b0;
      s_nxt.permit = 1'b0;
      s_nxt.done = 1'b0;
      s_nxt.sst = nvm_pkg::ST_IDLE;
      s_nxt.ust = nvm_pkg::UN_IDLE;
      s_nxt.tcnt = 32'h0;
      if (bor_rst_i) begin
        s_nxt.pwrt = 32'(PWRT_CYCLES);
      end
    end
  end

  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      s_r <= '0;
      s_r.mem <= '1;
      s_r.pwrt <= 32'(PWRT_CYCLES);
    end else begin
      s_r <= s_nxt;
    end
  end

  assign reg_rdata_o = s_r.rdata;
  assign prog_rdata_o = s_r.prd;
  assign store_done_o = s_r.done;
  assign store_busy_o = s_r.store;

endmodule // data_eeprom_access
`default_nettype wire

// file: test/nvm_chk_asserts.sv
`default_nettype none
module nvm_chk #(
  parameter int unsigned ERASE_CYCLES = 4,
  parameter int unsigned PROG_CYCLES = 4
) (
  // clock and resets
  input wire logic mclk_i,
  input wire logic rst_n_i,
  input wire logic ext_rst_i,
  input wire logic wdt_rst_i,
  input wire logic bor_rst_i,
  // registers, programmer, status
  input wire logic [2:0] reg_addr_i,
  input wire logic [7:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  input wire logic [7:0] reg_rdata_o,
  input wire logic prot_i,
  input wire logic prog_rd_i,
  input wire logic [7:0] prog_rdata_o,
  input wire logic store_done_o,
  input wire logic store_busy_o
);
  default clocking @(posedge mclk_i); endclocking
  default disable iff (!rst_n_i);
  logic sr;
  logic cw;
  int unsigned bcnt_r;
  assign sr = ext_rst_i | wdt_rst_i | bor_rst_i;
  assign cw = reg_wr_i && reg_addr_i == 3'h2;
  // cycles the store strobe has been up
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) bcnt_r <= 0;
    else bcnt_r <= store_busy_o ? bcnt_r + 1 : 0;
  end
  a_unlock_zero: assert property (reg_rd_i && reg_addr_i == 3'h3 |=> reg_rdata_o == 8'h00)
    else $error("unlock read");
  a_ctrl_upper: assert property (reg_rd_i && reg_addr_i == 3'h2 |=> reg_rdata_o[7:4] == 4'h0)
    else $error("ctrl upper");
  a_prog_hidden: assert property (prog_rd_i && prot_i |=> prog_rdata_o == 8'h00)
    else $error("prog read");
  a_store_len: assert property ($fell(store_busy_o) && store_done_o |-> bcnt_r == ERASE_CYCLES + PROG_CYCLES)
    else $error("store length");
  a_done_cause: assert property ($rose(store_done_o) |-> $fell(store_busy_o))
    else $error("done cause");
  a_done_hold: assert property (store_done_o && !sr && !(reg_wr_i && reg_addr_i == 3'h4) |=> store_done_o)
    else $error("done hold");
  a_busy_sticky: assert property (store_busy_o && !sr && cw |=> store_busy_o || store_done_o)
    else $error("busy cleared");
  a_start_seq: assert property ($rose(store_busy_o) |-> $past(cw) && $past(reg_wr_i, 3) && $past(reg_wr_i, 5)
    && $past(reg_wdata_i, 3) == 8'haa && $past(reg_wdata_i, 5) == 8'h55) else $error("bad start");
endmodule // nvm_chk
bind data_eeprom_access nvm_chk #(.ERASE_CYCLES(ERASE_CYCLES), .PROG_CYCLES(PROG_CYCLES)) chk (.mclk_i, .rst_n_i,
  .ext_rst_i, .wdt_rst_i, .bor_rst_i, .reg_addr_i, .reg_wdata_i, .reg_wr_i, .reg_rd_i, .reg_rdata_o, .prot_i,
  .prog_rd_i, .prog_rdata_o, .store_done_o, .store_busy_o);
`default_nettype wire

// file: test/testbench.sv
`default_nettype none
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  logic mclk_i = '0, rst_n_i = '0, ext_rst_i = '0, wdt_rst_i = '0, bor_rst_i = '0, reg_wr_i = '0, reg_rd_i = '0;
  logic prot_i = '0, prog_rd_i = '0, store_done_o, store_busy_o;
  logic [2:0] reg_addr_i = '0;
  logic [7:0] reg_wdata_i = '0, prog_addr_i = 8'h10, reg_rdata_o, prog_rdata_o, q;
  int n_mismatch = 0, checked = 0;
  always #12.5 mclk_i = ~mclk_i;
  data_eeprom_access #(.ERASE_CYCLES(4), .PROG_CYCLES(4), .PWRT_CYCLES(8)) uut (.mclk_i, .rst_n_i, .ext_rst_i,
    .wdt_rst_i, .bor_rst_i, .reg_addr_i, .reg_wdata_i, .reg_wr_i, .reg_rd_i, .reg_rdata_o, .prot_i,
    .prog_addr_i, .prog_rd_i, .prog_rdata_o, .store_done_o, .store_busy_o);
  task automatic ck(input string n, input logic [7:0] s, e);
    checked++;
    if (s !== e) begin
      n_mismatch++;
      $display("CHECK FAILED %s exp %h got %h", n, e, s);
    end
  endtask
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    reg_addr_i <= a;
    reg_wdata_i <= d;
    reg_wr_i <= 1'b1;
    @(posedge mclk_i);
    reg_wr_i <= 1'b0;
    @(posedge mclk_i);
  endtask
  task automatic rd(input logic [2:0] a);
    reg_addr_i <= a;
    reg_rd_i <= 1'b1;
    @(posedge mclk_i);
    reg_rd_i <= 1'b0;
    #1;
    q = reg_rdata_o;
    @(posedge mclk_i);
  endtask
  task automatic store(input logic [7:0] a, d);
    wr(3'h1, a);
    wr(3'h0, d);
    wr(3'h2, 8'h04);
    wr(3'h3, 8'h55);
    wr(3'h3, 8'haa);
    wr(3'h2, 8'h06);
  endtask
  task automatic t_regs();
    for (int i = 0; i < 6; i++) begin
      rd(i[2:0]);
      ck("reset", q, 8'h00);
    end
    wr(3'h2, 8'h02);
    rd(3'h2);
    ck("ctrl", q, 8'h00);
    $display("regs end");
  endtask
  task automatic t_store();
    store(8'h10, 8'ha5);
    ck("busy", {7'h0, store_busy_o}, 8'h01);
    wr(3'h2, 8'h00);
    ck("busy", {7'h0, store_busy_o}, 8'h01);
    for (int i = 0; i < 40 && store_busy_o; i++) @(negedge mclk_i);
    ck("done", {7'h0, store_done_o}, 8'h01);
    @(posedge mclk_i);
    rd(3'h4);
    ck("flag", q, 8'h80);
    wr(3'h1, 8'h10);
    wr(3'h2, 8'h01);
    rd(3'h0);
    ck("fetch", q, 8'ha5);
    $display("store end");
  endtask
  task automatic t_bad();
    wr(3'h2, 8'h04);
    wr(3'h3, 8'h55);
    @(posedge mclk_i);
    wr(3'h3, 8'haa);
    wr(3'h2, 8'h06);
    rd(3'h2);
    ck("ctrl", q, 8'h04);
    $display("bad end");
  endtask
  task automatic t_abort();
    store(8'h20, 8'h3c);
    ext_rst_i <= 1'b1;
    @(posedge mclk_i);
    ext_rst_i <= 1'b0;
    rd(3'h2);
    ck("ctrl", q, 8'h08);
    rd(3'h0);
    ck("data", q, 8'h00);
    rd(3'h1);
    ck("addr", q, 8'h00);
    wr(3'h2, 8'h00);
    rd(3'h2);
    ck("abort clear", q, 8'h00);
    $display("abort end");
  endtask
  task automatic t_prot();
    for (int p = 1; p >= 0; p--) begin
      prot_i <= p[0];
      prog_rd_i <= 1'b1;
      @(posedge mclk_i);
      prog_rd_i <= 1'b0;
      @(posedge mclk_i);
      ck("prog", prog_rdata_o, p ? 8'h00 : 8'ha5);
    end
    $display("prot end");
  endtask
  task automatic results();
    $display("checked %0d n_mismatch %0d", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  initial begin
    repeat (10) @(posedge mclk_i);
    rst_n_i <= 1'b1;
    @(posedge mclk_i);
    t_regs();
    t_store();
    t_bad();
    t_abort();
    t_prot();
    results();
  end
  initial begin
    #40us;
    n_mismatch++;
    results();
  end
endmodule // testbench
`default_nettype wire
